// ### hdl/asr_pkg.sv
/*
  Shared constants and types for the slave serial readout block.
  Assumes a 25 MHz system clock and a host-driven shift clock.
*/
package asr_pkg;

  // Result word width and the bit counter that walks it.
  localparam int WORD_BITS = 18;
  localparam int CNT_W     = 5;

  // Bit counter value once a whole word has gone out.
  localparam logic [CNT_W-1:0] CNT_DONE = 5'h12;
  localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;

  // Reset values.
  localparam logic [WORD_BITS-1:0] WORD_RST = 18'h00000;
  localparam logic [CNT_W-1:0]     CNT_RST  = CNT_DONE;

  // Conversion time in ns and its length in system clock cycles, rounded up.
  localparam int CLK_PERIOD_NS = 40;
  localparam int CONV_TIME_NS  = 400;
  localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_W        = 4;
  localparam logic [CONV_W-1:0] CONV_LAST = CONV_W'(CONV_CYCLES - 1);
  localparam logic [CONV_W-1:0] CONV_RST  = 4'h0;

  // Host-side limits, kept for reference by the surrounding system.
  localparam int HOST_SCLK_MAX_MHZ = 80;
  localparam int SPI_SCLK_MAX_MBPS = 17;
  localparam int SPI_BYTES_PER_RESULT = 3;

  // Conversion phase.
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } asr_state_e;

endpackage

// ### hdl/asr_readout.sv
/*
  Slave serial readout of an 18-bit converter: conversion timing, result
  holding, read-overrun detection and the shift-clock side shifter.
  Assumes sample_data comes from the converter core on the system clock and
  that the host drives sclk, cs_n and rd_n synchronously to one another.
*/
`timescale 1ns/1ns
//
// Contract
// RULE1: After busy falls, result readable with select low.
// RULE2: MSB first, one bit per clock, 18.
// RULE3: Each bit valid across both clock edges.
// RULE4: Host clock up to 80 MHz.
// RULE5: Chain input follows own result when cascading.
// RULE6: Chain input latched on opposite clock edge.
// RULE7: Upstream MSB right after own LSB.
// RULE8: Host shares one convert start for cascade.
// RULE9: During conversion, previous result shifts out.
// RULE10: Host reads 18 bits before conversion ends.
// RULE11: Unfinished read at conversion end pulses error.
// RULE12: Chain input tied fixed when reading during.
// RULE13: Reading allowed any time after start.
// RULE14: Host should read in first half.
// RULE15: SPI host uses three byte transfers.
// RULE16: SPI host master, polarity 0, phase 1.
// RULE17: SPI host clock limited to 17 Mbit/s.
// RULE18: Slow host reads after busy falls.
// RULE19: Serial interface when both selects high.
// RULE20: Slave clocking when clock source high.
// RULE21: Shift clock ignored while chip select high.
// RULE22: Data output undriven unless selected and enabled.
// RULE23: After full read, next word MSB shown.
module asr_readout
  import asr_pkg::*;
(
  // System clock and synchronous reset.
  input  wire logic                 clock,
  input  wire logic                 rst,
  // Host link.
  input  wire logic                 sclk,
  input  wire logic                 cs_n,
  input  wire logic                 rd_n,
  input  wire logic                 chain_in_or_read_select,
  output logic                      serial_data_out,
  output logic                      serial_data_oe,
  // Conversion control and status.
  input  wire logic                 convert_start_n,
  output logic                      busy,
  output logic                      read_overrun_flag,
  // Interface straps.
  input  wire logic                 interface_select_lo,
  input  wire logic                 interface_select_hi,
  input  wire logic                 clock_source_select,
  // Result from the converter core.
  input  wire logic [WORD_BITS-1:0] sample_data
);

  // System-domain state.
  asr_state_e             state_r, state_nxt;
  logic [CONV_W-1:0]      conv_cnt_r, conv_cnt_nxt;
  logic                   busy_r, busy_nxt;
  logic [WORD_BITS-1:0]   word_r, word_nxt;
  logic                   ld_tgl_r, ld_tgl_nxt;
  logic                   err_r, err_nxt;
  logic                   cnv_prev_r, cnv_prev_nxt;
  logic [4:0]             sys_sync;
  logic                   cnv_s, en_s, mid_s, conv_end;

  // Link-domain state.
  logic [WORD_BITS-1:0]   sr_r, sr_nxt;
  logic [CNT_W-1:0]       cnt_r, cnt_nxt;
  logic                   seen_r, seen_nxt;
  logic                   mid_r, mid_nxt;
  logic                   chain_lat_r, chain_lat_nxt;
  logic [1:0]             link_sync;
  logic                   lrst, en_l, active, pending;

  // Pins and the link-side progress level cross into the system clock.
  asr_sync #(.W(5)) u_sys_sync (
    .clk (clock),
    .rst (rst),
    .d   ({~convert_start_n, interface_select_lo, interface_select_hi,
           clock_source_select, mid_r}),
    .q   (sys_sync)
  );

  // Reset and serial enable cross into the shift-clock domain.
  asr_sync #(.W(2)) u_link_sync (
    .clk (sclk),
    .rst (1'b0),
    .d   ({rst, en_s}),
    .q   (link_sync)
  );

  // Unpack synchronised levels; the strap product selects slave serial mode.
  // RULE19 RULE20 serial slave select.
  always_comb begin
    cnv_s = !sys_sync[4]; // The lane carries the inverted pin, so reset reads as idle.
    en_s  = sys_sync[3] & sys_sync[2] & sys_sync[1];
    mid_s = sys_sync[0];
    lrst  = link_sync[1];
    en_l  = link_sync[0];
  end

  // Conversion sequencer: a falling convert start runs a fixed conversion,
  // and a new start during a conversion is ignored.
  always_comb begin
    state_nxt    = state_r;
    conv_cnt_nxt = conv_cnt_r;
    word_nxt     = word_r;
    ld_tgl_nxt   = ld_tgl_r;
    err_nxt      = 1'b0;
    cnv_prev_nxt = cnv_s;
    conv_end     = (state_r == ST_CONV) && (conv_cnt_r == CONV_LAST);
    case (state_r)
      ST_IDLE: begin
        if (cnv_prev_r && !cnv_s) begin
          state_nxt    = ST_CONV;
          conv_cnt_nxt = CONV_RST;
        end
      end
      ST_CONV: begin
        conv_cnt_nxt = conv_cnt_r + 4'h1;
        if (conv_end) begin
          // RULE1 new result published.
          state_nxt  = ST_IDLE;
          word_nxt   = sample_data;
          ld_tgl_nxt = ~ld_tgl_r;
          // RULE11 overrun error pulse.
          err_nxt    = mid_s;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    busy_nxt = (state_nxt == ST_CONV);
    if (rst) begin
      state_nxt    = ST_IDLE;
      conv_cnt_nxt = CONV_RST;
      word_nxt     = WORD_RST;
      ld_tgl_nxt   = 1'b0;
      err_nxt      = 1'b0;
      cnv_prev_nxt = 1'b1;
      busy_nxt     = 1'b0;
    end
  end

  // System-domain registers.
  always_ff @(posedge clock) begin
    state_r    <= state_nxt;
    conv_cnt_r <= conv_cnt_nxt;
    busy_r     <= busy_nxt;
    word_r     <= word_nxt;
    ld_tgl_r   <= ld_tgl_nxt;
    err_r      <= err_nxt;
    cnv_prev_r <= cnv_prev_nxt;
  end

  // The held word and its toggle change only at conversion end, when the
  // host is not clocking, so the shifter treats them as static.
  // RULE13 RULE21 gated shift enable.
  always_comb begin
    active  = !cs_n && !rd_n && en_l;
    pending = ld_tgl_r ^ seen_r;
  end

  // Shifter: a fresh word loads on its first falling edge with the chain bit
  // entering at the bottom, so the upstream word trails our own.
  always_comb begin
    sr_nxt   = sr_r;
    cnt_nxt  = cnt_r;
    seen_nxt = seen_r;
    if (active) begin
      if (pending) begin
        // RULE2 RULE9 MSB first load.
        sr_nxt   = {word_r[WORD_BITS-2:0], chain_lat_r};
        cnt_nxt  = CNT_ONE;
        seen_nxt = ld_tgl_r;
      end else begin
        // RULE5 RULE7 chain follows LSB.
        sr_nxt = {sr_r[WORD_BITS-2:0], chain_lat_r};
        if (cnt_r < CNT_DONE) begin
          cnt_nxt = cnt_r + CNT_ONE;
        end
      end
    end
    mid_nxt = (cnt_nxt != CNT_DONE);
    if (lrst) begin
      sr_nxt   = WORD_RST;
      cnt_nxt  = CNT_RST;
      seen_nxt = 1'b0;
      mid_nxt  = 1'b0;
    end
  end

  // Data moves on the falling edge so each bit spans the following rising one.
  // RULE3 falling edge shift.
  always_ff @(negedge sclk) begin
    sr_r   <= sr_nxt;
    cnt_r  <= cnt_nxt;
    seen_r <= seen_nxt;
    mid_r  <= mid_nxt;
  end

  // RULE6 chain opposite edge.
  always_comb begin
    chain_lat_nxt = lrst ? 1'b0 : (active ? chain_in_or_read_select : chain_lat_r);
  end

  // Chain input latch on the rising edge.
  always_ff @(posedge sclk) begin
    chain_lat_r <= chain_lat_nxt;
  end

  // Outputs; an unread word shows its MSB without any host command.
  // RULE23 next MSB shown.
  assign serial_data_out = pending ? word_r[WORD_BITS-1] : sr_r[WORD_BITS-1];
  // RULE22 output enable gating.
  assign serial_data_oe    = !cs_n && !rd_n && en_s;
  assign busy              = busy_r;
  assign read_overrun_flag = err_r;

  // Busy stays high for the conversion after a start.
  property p_busy_len;
    @(posedge clock) disable iff (rst)
      $rose(busy_r) |-> busy_r [*8] ##1 busy_r [*2] ##1 !busy_r;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong"); // RULE1

  // The published word is the core sample at the end of conversion.
  property p_load;
    @(posedge clock) disable iff (rst)
      $fell(busy_r) |-> (word_r == $past(sample_data)) && (ld_tgl_r != $past(ld_tgl_r));
  endproperty
  a_load: assert property (p_load) else $error("result not loaded"); // RULE1

  // An unfinished read at conversion end pulses the error for one cycle.
  property p_err_set;
    @(posedge clock) disable iff (rst)
      conv_end && mid_s |=> read_overrun_flag ##1 !read_overrun_flag;
  endproperty
  a_err_set: assert property (p_err_set) else $error("overrun not flagged"); // RULE11

  // The error pulse has no other cause.
  property p_err_cause;
    @(posedge clock) disable iff (rst)
      read_overrun_flag |-> $past(conv_end) && $past(mid_s);
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("spurious overrun"); // RULE11

  // No drive while deselected or in another interface mode.
  property p_oe;
    @(posedge clock) disable iff (rst)
      (cs_n || rd_n || !en_s) |-> !serial_data_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("output driven while off"); // RULE22

  // A strap held low for three cycles keeps the data pin released.
  property p_strap_off;
    @(posedge clock) disable iff (rst)
      (!interface_select_lo || !interface_select_hi || !clock_source_select) [*3]
        |-> !serial_data_oe;
  endproperty
  a_strap_off: assert property (p_strap_off) else $error("driven in another mode"); // RULE19

  // After the MSB, the next falling edge shows bit 16 of the word.
  property p_msb_first;
    @(negedge sclk) disable iff (lrst)
      active && pending |=> !pending && (serial_data_out == word_r[WORD_BITS-2]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("wrong second bit"); // RULE2

  // The bit latched on the rising edge enters at the bottom.
  property p_chain;
    @(negedge sclk) disable iff (lrst)
      active |=> sr_r[0] == $past(chain_lat_r);
  endproperty
  a_chain: assert property (p_chain) else $error("chain bit lost"); // RULE5

  // With chip select high, the shifter holds still.
  property p_gate;
    @(negedge sclk) disable iff (lrst)
      cs_n |=> $stable(sr_r) && $stable(cnt_r);
  endproperty
  a_gate: assert property (p_gate) else $error("shifted while deselected"); // RULE21

  // Eighteen shifts from a fresh load end the word.
  sequence s_fresh;
    active && pending;
  endsequence
  property p_word_len;
    @(negedge sclk) disable iff (lrst)
      s_fresh ##1 (active && !pending) [*8] ##1 (active && !pending) [*8]
        ##1 active |=> (cnt_r == CNT_DONE) && !mid_r;
  endproperty
  a_word_len: assert property (p_word_len) else $error("word length wrong"); // RULE7

endmodule

// ### hdl/asr_sync.sv
/*
  Two-flop level synchroniser, one lane per bit.
  Assumes each input is a level that stays put for several destination clocks.
*/
`timescale 1ns/1ns
module asr_sync #(
  parameter int W = 1
) (
  // Destination clock and synchronous reset.
  input  wire logic         clk,
  input  wire logic         rst,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_nxt = rst ? '0 : d;
    q_nxt    = rst ? '0 : meta_r;
  end

  // Register both stages.
  always_ff @(posedge clk) begin
    meta_r <= meta_nxt;
    q_r    <= q_nxt;
  end

  assign q = q_r;

endmodule

// ### testbench/asr_host_model.sv
/*
  Host model: clock master of the shift clock, reads frames MSB first.
  Assumes the clock idles low and runs inside frames and in idle bursts, 80 ns period.
*/
`timescale 1ns/1ns
module asr_host_model (
  // Pins driven by the host.
  output logic        sclk,
  output logic        cs_n,
  output logic        rd_n,
  output logic        chain_in_or_read_select,
  // Pins from the device.
  input  wire logic   serial_data_out,
  input  wire logic   serial_data_oe,
  // Frame seen after each rising edge and just before each falling edge.
  output logic [35:0] got_r,
  output logic [35:0] got_f,
  output logic        fdone
);
  logic last_bit;

  // A released line shows the inverse of the last bit, never a stale copy.
  function automatic logic line_level();
    return serial_data_oe ? serial_data_out : ~last_bit;
  endfunction

  // Start idle with the clock low and the port deselected.
  initial begin
    {sclk, chain_in_or_read_select, fdone, last_bit} = 4'h0;
    {cs_n, rd_n} = 2'h3;
    got_r = 36'h0;
    got_f = 36'h0;
  end

  // Sets chip select and read enable levels.
  task automatic pins(input logic c, input logic r);
    cs_n = c;
    rd_n = r;
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
    end
  endtask

  // 80 ns shift clock, well under both limits.
  // chain bit set mid-low, stable at the rising edge.
  task automatic frame(input int n, input logic [35:0] ch);
    got_r = 36'h0;
    got_f = 36'h0;
    pins(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      #20 chain_in_or_read_select = ch[35-i];
      #20 sclk = 1'b1;
      #1 got_r = {got_r[34:0], line_level()};
      #38 got_f = {got_f[34:0], line_level()};
      last_bit = got_f[0];
      #1 sclk = 1'b0;
    end
    #40 pins(1'b1, 1'b1);
    chain_in_or_read_select = ~chain_in_or_read_select;
    fdone = 1'b1;
    #1 fdone = 1'b0;
  endtask
endmodule

// ### testbench/asr_readout_tb.sv
/*
  Self-checking bench of the serial readout, with queued frame results.
  Assumes a 25 MHz clock and the host model as the link clock master.
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp=%h got=%h", nm, e, g); end end
module asr_readout_tb;
  import asr_pkg::*;
  logic                 clock, rst, sclk, cs_n, rd_n, chain, sdo, oe;
  logic                 cnv_n, busy, ovr, fdone;
  logic [2:0]           straps;
  logic [WORD_BITS-1:0] sample, prev;
  logic [35:0]          got_r, got_f, ch;
  logic [35:0]          exp_q[$];
  logic [31:0]          seed;
  int                   fails, comparisons, ovr_cnt;

  asr_readout dut_u (.clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .rd_n(rd_n),
    .chain_in_or_read_select(chain), .serial_data_out(sdo), .serial_data_oe(oe),
    .convert_start_n(cnv_n), .busy(busy), .read_overrun_flag(ovr),
    .interface_select_lo(straps[0]), .interface_select_hi(straps[1]),
    .clock_source_select(straps[2]), .sample_data(sample));
  asr_host_model host_u (.sclk(sclk), .cs_n(cs_n), .rd_n(rd_n),
    .chain_in_or_read_select(chain), .serial_data_out(sdo), .serial_data_oe(oe),
    .got_r(got_r), .got_f(got_f), .fdone(fdone));

  // System clock.
  always #20 clock = ~clock;

  // Counts overrun pulses, one per clock they stand, sampled mid-cycle.
  always @(negedge clock) begin
    if (ovr === 1'b1) ovr_cnt++;
  end

  // Compares each finished frame with the oldest queued expectation.
  always @(posedge fdone) begin
    logic [35:0] e;
    e = exp_q.pop_front();
    `CHK("frame_rise", e, got_r)
    `CHK("frame_fall", e, got_f)
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Starts a conversion and measures how long busy stands.
  task automatic convert();
    int n;
    @(posedge clock) cnv_n <= 1'b0;
    @(posedge clock) cnv_n <= 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 8) begin
      @(posedge clock) #1 n++;
    end
    n = 0;
    while (busy === 1'b1 && n < 20) begin
      @(posedge clock) #1 n++;
    end
    `CHK("busy_len", CONV_CYCLES, n)
    repeat (3) @(posedge clock);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #100000 fails++;
    print_verdict();
  end

  initial begin
    {clock, cnv_n, rst, straps, sample, seed} = {3'h3, 3'h7, 18'h0, 32'h0000e802};
    {fails, comparisons, ovr_cnt} = 0;
    fork
      begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
      end
      host_u.idle(4);
    join
    host_u.idle(3);
    repeat (6) @(posedge clock);
    #1 `CHK("oe_idle", 1'b0, oe)
    // word followed by the upstream word, three rounds.
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      @(posedge clock) sample <= seed[17:0];
      convert();
      seed = xs(seed);
      ch = {seed[17:0], seed[31:14]};
      exp_q.push_back({sample, ch[35:18]});
      host_u.frame(36, ch);
    end
    `CHK("no_ovr", 0, ovr_cnt)
    // partial read of an unread word during the next conversion.
    prev = sample;
    convert();
    @(posedge clock) sample <= ~prev;
    exp_q.push_back({34'h0, prev[17:16]});
    fork
      convert();
      begin
        wait (busy === 1'b1);
        host_u.frame(2, 36'h0);
      end
    join
    repeat (2) @(posedge clock);
    `CHK("ovr_pulse", 1, ovr_cnt)
    host_u.idle(5);
    host_u.pins(1'b0, 1'b1);
    #1 `CHK("oe_rd_high", 1'b0, oe)
    host_u.pins(1'b1, 1'b1);
    // ignored pulses leave the new word whole.
    exp_q.push_back({12'h0, ~prev, 6'h0});
    host_u.frame(24, 36'h0);
    // any strap low keeps the port off.
    for (int k = 0; k < 4; k++) begin
      @(posedge clock) straps <= (k < 3) ? 3'h7 ^ (3'h1 << k) : 3'h7;
      repeat (6) @(posedge clock);
      host_u.idle(3);
      host_u.pins(1'b0, 1'b0);
      #1 `CHK("oe_strap", (k == 3), oe)
      host_u.pins(1'b1, 1'b1);
    end
    print_verdict();
  end
endmodule
